// file: pkg/btc_pkg.sv
package btc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CNT_W = 16;
  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] PERIOD_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] IDLE_ADDR = 8'h0c;
  // control field positions
  localparam int unsigned ENABLE_BIT = 15;
  localparam int unsigned STOP_IDLE_BIT = 13;
  localparam int unsigned WR_DIS_BIT = 12;
  localparam int unsigned WIP_BIT = 11;
  localparam int unsigned ECS_LO = 8;
  localparam int unsigned GATE_BIT = 7;
  localparam int unsigned PRESCALE_LO = 4;
  localparam int unsigned SYNC_BIT = 2;
  localparam int unsigned CS_BIT = 1;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000_b3b6;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hffff;
  // external clock selection codes
  localparam logic [1:0] ECS_SOSC = 2'h0;
  localparam logic [1:0] ECS_PIN = 2'h1;
  localparam logic [1:0] ECS_RC_OSC = 2'h2;
  // cycles for an asynchronous counter write to settle in the timer
  localparam int unsigned ASYNC_WR_CYCLES = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic stop_in_idle;
    logic async_write_disable;
    logic [1:0] external_clock_select;
    logic gated_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_clock_sync;
    logic clock_source_select;
  } btc_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } btc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } btc_axi_rsp_t;
endpackage

// file: verification/btc_timer_checker.sv
`timescale 1ns/1ps
module btc_checker #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire btc_pkg::btc_axi_req_t axi_req,
  input wire btc_pkg::btc_axi_rsp_t axi_rsp,
  input wire logic device_idle,
  input wire logic gate_in,
  input wire logic [CNT_W-1:0] counter_value
);
  import btc_pkg::*;
  logic [7:0] aw_q, ar_q;
  logic [15:0] w_q, c_q;
  logic [3:0] qt_q;
  // shadow of control, applied at the write response; qt_q waits out loads in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h0;
      ar_q <= 8'h0;
      w_q <= 16'h0;
      c_q <= 16'h0;
      qt_q <= 4'h0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) aw_q <= axi_req.awaddr;
      if (axi_req.wvalid && axi_rsp.wready) w_q <= axi_req.wdata[15:0];
      if (axi_req.arvalid && axi_rsp.arready) ar_q <= axi_req.araddr;
      if (axi_rsp.bvalid && axi_req.bready && aw_q == CTRL_ADDR) c_q <= w_q;
      qt_q <= (axi_req.awvalid || axi_rsp.bvalid) ? 4'h0 : qt_q + {3'h0, qt_q != 4'h8};
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_off_hold: assert property (qt_q == 4'h8 && !c_q[ENABLE_BIT] |=> $stable(counter_value))
    else $error("count moved while off");
  a_run_step: assert property (qt_q == 4'h8 && (c_q & 16'hb3b6) == 16'h8000
    |=> counter_value == $past(counter_value) + 1'b1)
    else $error("count did not step");
  a_idle_halt: assert property ((qt_q == 4'h8 && c_q[STOP_IDLE_BIT] && device_idle)[*3]
    |=> $stable(counter_value))
    else $error("count moved in idle");
  a_gate_halt: assert property ((qt_q == 4'h8 && c_q[ENABLE_BIT] && c_q[GATE_BIT]
    && !c_q[CS_BIT] && !gate_in)[*5] |=> $stable(counter_value))
    else $error("count moved with gate low");
  a_wip_sync: assert property (axi_rsp.rvalid && ar_q == CTRL_ADDR
    && !(c_q[CS_BIT] && !c_q[SYNC_BIT]) |-> !axi_rsp.rdata[WIP_BIT])
    else $error("busy flag set in sync mode");
  a_upper_zero: assert property (axi_rsp.rvalid && ar_q == CTRL_ADDR
    |-> (axi_rsp.rdata & ~(CTRL_WMASK | 32'h800)) == 32'h0)
    else $error("unused control bit set");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_write_answer: assert property (axi_req.awvalid && axi_req.wvalid && axi_rsp.awready
    && axi_rsp.wready |=> !axi_rsp.awready ##1 axi_rsp.bvalid)
    else $error("write answer late");
  a_unmapped_err: assert property (axi_rsp.rvalid && ar_q > IDLE_ADDR
    |-> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // btc_checker

bind btc_timer btc_checker #(.CNT_W(CNT_W)) chk_i (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .device_idle(device_idle), .gate_in(gate_in),
  .counter_value(counter_value));

// file: verification/tb_basic_timer_control.sv
`timescale 1ns/1ps
module tb_basic_timer_control;
  import btc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  btc_axi_req_t q = '0;
  btc_axi_rsp_t s;
  logic idle = 1'b0;
  logic gate = 1'b0;
  logic [2:0] src = 3'h0;
  logic [15:0] cnt;
  logic [31:0] rd;
  logic [1:0] rs;
  logic ok;
  logic pm;
  int hits = 0;
  // {control[15:0], idle, gate}
  logic [17:0] tv [6] = '{18'h0, 18'h20000, 18'h28002, 18'h20002, 18'h20200, 18'h20201};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #4 aclk = ~aclk;
  btc_timer uut (.aclk(aclk), .aresetn(aresetn), .axi_req(q), .axi_rsp(s),
    .device_idle(idle), .secondary_osc(src[0]), .timer_clock_pin(src[1]),
    .low_power_rc_osc(src[2]), .gate_in(gate), .counter_value(cnt), .period_match(pm));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // now: start on the edge the previous write ended on, to land inside a pending async write
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit now = 1'b0);
    if (!now) @(posedge aclk);
    q.awaddr <= a;
    q.wdata <= d;
    q.wstrb <= 4'hf;
    q.awvalid <= 1'b1;
    q.wvalid <= 1'b1;
    q.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s.awready === 1'b1) q.awvalid <= 1'b0;
      if (s.wready === 1'b1) q.wvalid <= 1'b0;
    end while (s.bvalid !== 1'b1);
    rs = s.bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    q.araddr <= a;
    q.arvalid <= 1'b1;
    q.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s.arready === 1'b1) q.arvalid <= 1'b0;
    end while (s.rvalid !== 1'b1);
    rd = s.rdata;
    rs = s.rresp;
    q.rready <= 1'b0;
  endtask
  // gate and edge inputs pass three flops, so settle before measuring
  task automatic rate(input logic [15:0] e);
    logic [15:0] a;
    repeat (6) @(posedge aclk);
    #1 a = cnt;
    repeat (4) @(posedge aclk);
    #1 chk({16'h0, cnt - a}, {16'h0, e});
  endtask
  task automatic pulse(input int k);
    repeat (5) begin
      @(posedge aclk);
      src[k] <= 1'b1;
      repeat (3) @(posedge aclk);
      src[k] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(CTRL_ADDR);
    chk(rd, CTRL_RESET);
    rd_reg(PERIOD_ADDR);
    chk(rd, {16'h0, PERIOD_RESET});
    wr(CTRL_ADDR, 32'hffff_ffff);
    rd_reg(CTRL_ADDR);
    chk(rd, CTRL_WMASK);
    rd_reg(8'h10);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(IDLE_ADDR, 32'h1);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("register map done");
    foreach (tv[i]) begin
      wr(CTRL_ADDR, {16'h0, tv[i][17:2]});
      idle <= tv[i][1];
      gate <= tv[i][0];
      ok = tv[i][17] && !(tv[i][15] && tv[i][1]) && !(tv[i][9] && !tv[i][0]);
      rate(ok ? 16'h4 : 16'h0);
      rd_reg(IDLE_ADDR);
      chk(rd, {31'h0, tv[i][1]});
    end
    $display("internal count done");
    idle <= 1'b0;
    gate <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_ADDR, {16'h0, 6'h20, k[1:0], 8'h86});
      wr(COUNT_ADDR, 32'h0);
      pulse(k % 3);
      repeat (8) @(posedge aclk);
      #1 chk({16'h0, cnt}, k < 3 ? 32'h5 : 32'h0);
    end
    $display("clock select done");
    wr(CTRL_ADDR, 32'h2);
    fork
      wr(COUNT_ADDR, 32'h11);
      begin
        // read once the write has been taken, while it is still settling
        repeat (2) @(posedge aclk);
        rd_reg(CTRL_ADDR);
      end
    join
    chk(rd, 32'h802);
    repeat (8) @(posedge aclk);
    rd_reg(CTRL_ADDR);
    chk(rd, 32'h2);
    chk({16'h0, cnt}, 32'h11);
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_ADDR, k ? 32'h1002 : 32'h2);
      wr(COUNT_ADDR, 32'h22);
      wr(COUNT_ADDR, 32'h33, 1'b1);
      repeat (8) @(posedge aclk);
      chk({16'h0, cnt}, k ? 32'h22 : 32'h33);
    end
    $display("async writes done");
    // period 3 at prescale 8 wraps every 32 cycles: two pulses in any 64
    wr(CTRL_ADDR, 32'h0);
    wr(COUNT_ADDR, 32'h0);
    wr(PERIOD_ADDR, 32'h3);
    wr(CTRL_ADDR, 32'h8010);
    repeat (64) begin
      @(posedge aclk);
      #1 if (pm === 1'b1) hits++;
    end
    chk(hits, 32'h2);
    $display("period match done");
    stop_test;
  end
endmodule // tb_basic_timer_control

// file: verilog/btc_timer.sv
`timescale 1ns/1ps
// Functional notes
// - the counter advances only while the enable bit is set.
// - with stop-in-idle set the counter halts while the device idles, else it keeps running.
// - with write-disable set, a counter write during a pending async write is dropped.
// - with write-disable clear, back-to-back counter writes are all accepted.
// - in async mode the write-in-progress flag is 1 while a counter write settles, else 0.
// - in sync mode the write-in-progress flag reads 0.
// - the external clock select picks oscillator, timer clock pin or RC oscillator; 11 none.
// - with clock source select 1, the gate enable has no effect.
// - with clock source select 0, the gate enable turns gated accumulation on and off.
// - unimplemented control bits, upper halfword included, read 0 and ignore writes.
module btc_timer #(
  parameter int unsigned CNT_W = btc_pkg::CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire btc_pkg::btc_axi_req_t axi_req,
  output btc_pkg::btc_axi_rsp_t axi_rsp,
  input wire logic device_idle,
  input wire logic secondary_osc,
  input wire logic timer_clock_pin,
  input wire logic low_power_rc_osc,
  input wire logic gate_in,
  output logic [CNT_W-1:0] counter_value,
  output logic period_match
);
  import btc_pkg::*;

  typedef struct packed {
    btc_ctrl_t ctrl;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] pend_val;
    logic [1:0] wip_cnt;
    logic [2:0] ext_sync;
    logic [2:0] gate_sync;
    logic ext_prev;
    logic [7:0] pre_cnt;
    logic match;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } btc_state_t;

  btc_state_t s_q;
  btc_state_t s_d;

  logic ext_sel;
  logic ext_level;
  logic ext_rise;
  logic gate_level;
  logic run;
  logic tick_src;
  logic tick;
  logic async_mode;
  logic wip;
  logic [7:0] pre_lim;
  logic [DATA_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] wmerge;
  logic [DATA_W-1:0] wold;
  logic do_write;
  logic wr_ok;

  // external clock mux; reserved code gives a still source
  always_comb begin
    case (s_q.ctrl.external_clock_select)
      ECS_SOSC: ext_sel = secondary_osc;
      ECS_PIN: ext_sel = timer_clock_pin;
      ECS_RC_OSC: ext_sel = low_power_rc_osc;
      default: ext_sel = 1'b0;
    endcase
  end

  // synchronisers: clock edge counts once stages 2 and 3 agree; gate reads high only while both are high
  assign ext_level = (s_q.ext_sync[1] == s_q.ext_sync[2]) ? s_q.ext_sync[2] : s_q.ext_prev;
  assign ext_rise = ext_level && !s_q.ext_prev;
  assign gate_level = s_q.gate_sync[1] & s_q.gate_sync[2];

  assign async_mode = s_q.ctrl.clock_source_select && !s_q.ctrl.external_clock_sync;
  assign wip = async_mode && (s_q.wip_cnt != 2'h0);

  assign run = s_q.ctrl.enable && !(s_q.ctrl.stop_in_idle && device_idle);

  always_comb begin
    if (s_q.ctrl.clock_source_select) begin
      tick_src = ext_rise;
    end else if (s_q.ctrl.gated_accumulate_enable) begin
      tick_src = gate_level;
    end else begin
      tick_src = 1'b1;
    end
  end

  always_comb begin
    case (s_q.ctrl.prescale_select)
      2'h0: pre_lim = 8'h00;
      2'h1: pre_lim = 8'h07;
      2'h2: pre_lim = 8'h3f;
      default: pre_lim = 8'hff;
    endcase
  end

  assign tick = run && tick_src && (s_q.pre_cnt == pre_lim);

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[ENABLE_BIT] = s_q.ctrl.enable;
    ctrl_rd[STOP_IDLE_BIT] = s_q.ctrl.stop_in_idle;
    ctrl_rd[WR_DIS_BIT] = s_q.ctrl.async_write_disable;
    ctrl_rd[WIP_BIT] = wip;
    ctrl_rd[ECS_LO +: 2] = s_q.ctrl.external_clock_select;
    ctrl_rd[GATE_BIT] = s_q.ctrl.gated_accumulate_enable;
    ctrl_rd[PRESCALE_LO +: 2] = s_q.ctrl.prescale_select;
    ctrl_rd[SYNC_BIT] = s_q.ctrl.external_clock_sync;
    ctrl_rd[CS_BIT] = s_q.ctrl.clock_source_select;
  end

  always_comb begin
    case (s_q.aw_addr)
      CTRL_ADDR: wold = ctrl_rd;
      COUNT_ADDR: wold = {{(DATA_W-CNT_W){1'b0}}, s_q.count};
      PERIOD_ADDR: wold = {{(DATA_W-CNT_W){1'b0}}, s_q.period};
      default: wold = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = s_q.w_strb[i] ? s_q.w_data[i*8 +: 8] : wold[i*8 +: 8];
    end
  end

  assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign wr_ok = (s_q.aw_addr == CTRL_ADDR) || (s_q.aw_addr == COUNT_ADDR)
    || (s_q.aw_addr == PERIOD_ADDR);

  always_comb begin
    s_d = s_q;
    s_d.ext_sync = {s_q.ext_sync[1:0], ext_sel};
    s_d.gate_sync = {s_q.gate_sync[1:0], gate_in};
    s_d.ext_prev = ext_level;
    s_d.match = 1'b0;

    if (run && tick_src) begin
      s_d.pre_cnt = (s_q.pre_cnt == pre_lim) ? 8'h00 : s_q.pre_cnt + 8'h01;
    end
    if (tick) begin
      if (s_q.count == s_q.period) begin
        s_d.count = '0;
        s_d.match = 1'b1;
      end else begin
        s_d.count = s_q.count + 1'b1;
      end
    end

    // async write settles after a fixed delay, then lands in the counter
    if (s_q.wip_cnt != 2'h0) begin
      s_d.wip_cnt = s_q.wip_cnt - 2'h1;
      if (s_q.wip_cnt == 2'h1) begin
        s_d.count = s_q.pend_val;
      end
    end

    if (axi_req.awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (do_write) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (s_q.aw_addr == CTRL_ADDR) begin
        s_d.ctrl.enable = wmerge[ENABLE_BIT] & CTRL_WMASK[ENABLE_BIT];
        s_d.ctrl.stop_in_idle = wmerge[STOP_IDLE_BIT];
        s_d.ctrl.async_write_disable = wmerge[WR_DIS_BIT];
        s_d.ctrl.external_clock_select = wmerge[ECS_LO +: 2];
        s_d.ctrl.gated_accumulate_enable = wmerge[GATE_BIT];
        s_d.ctrl.prescale_select = wmerge[PRESCALE_LO +: 2];
        s_d.ctrl.external_clock_sync = wmerge[SYNC_BIT];
        s_d.ctrl.clock_source_select = wmerge[CS_BIT];
      end else if (s_q.aw_addr == COUNT_ADDR) begin
        if (!async_mode) begin
          s_d.count = wmerge[CNT_W-1:0];
        end else if (!(s_q.ctrl.async_write_disable && s_q.wip_cnt != 2'h0)) begin
          s_d.pend_val = wmerge[CNT_W-1:0];
          s_d.wip_cnt = 2'(ASYNC_WR_CYCLES);
        end
      end else if (s_q.aw_addr == PERIOD_ADDR) begin
        s_d.period = wmerge[CNT_W-1:0];
      end
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
    end

    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (axi_req.araddr)
        CTRL_ADDR: s_d.rdata = ctrl_rd;
        COUNT_ADDR: s_d.rdata = {{(DATA_W-CNT_W){1'b0}}, s_q.count};
        PERIOD_ADDR: s_d.rdata = {{(DATA_W-CNT_W){1'b0}}, s_q.period};
        IDLE_ADDR: s_d.rdata = {{(DATA_W-1){1'b0}}, device_idle};
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.period <= PERIOD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp.awready = !s_q.aw_got;
  assign axi_rsp.wready = !s_q.w_got;
  assign axi_rsp.bvalid = s_q.bvalid;
  assign axi_rsp.bresp = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid = s_q.rvalid;
  assign axi_rsp.rdata = s_q.rdata;
  assign axi_rsp.rresp = s_q.rresp;
  assign counter_value = s_q.count;
  assign period_match = s_q.match;
endmodule // btc_timer
